// ==== hdl/ephy_pkg.sv ====
package ephy_pkg;
	// Arbitrary identifier values, not tied to any maker
	localparam logic [15:0] ID1 = 16'h0A5A;
	localparam logic [15:0] ID2 = 16'hC3C0;
	localparam logic [4:0] PHY_ADDR = 5'h01;
	localparam logic [4:0] R_CTRL = 5'h00;
	localparam logic [4:0] R_STAT = 5'h01;
	localparam logic [4:0] R_ID1 = 5'h02;
	localparam logic [4:0] R_ID2 = 5'h03;
	localparam logic [4:0] R_ADV = 5'h04;
	localparam logic [4:0] R_LP = 5'h05;
	localparam logic [4:0] R_EXP = 5'h06;
	localparam logic [7:0] OFS_MII_END = 8'h1C;
	localparam logic [7:0] OFS_CHIPRST = 8'h40;
	localparam logic [7:0] OFS_IRQST = 8'h44;
	localparam logic [7:0] OFS_IRQMASK = 8'h48;
	localparam logic [7:0] OFS_RESULT = 8'h4C;
	localparam int B_CTRL_RST = 15;
	localparam int B_SPD = 13;
	localparam int B_ANEN = 12;
	localparam int B_RESTART = 9;
	localparam int B_DUP = 8;
	localparam int B_CHIP_VRST = 3;
	localparam int B_CHIP_DRST = 10;
	localparam int I_AN = 0;
	localparam int I_MDWR = 1;
	localparam int I_VRST = 2;
	localparam logic [15:0] CTRL_RST = 16'h3100;
	localparam logic [15:0] CTRL_WMASK = 16'h7D80;
	localparam logic [15:0] STAT_BASE = 16'h780D;
	localparam logic [15:0] ADV_RST = 16'h01E1;
	localparam logic [15:0] ADV_WMASK = 16'h0DE0;
	localparam logic [15:0] SEL_8023 = 16'h0001;
	localparam logic [5:0] PRE_ONES = 6'h20;
	localparam logic [1:0] MD_OP_RD = 2'h2;
	localparam logic [1:0] MD_OP_WR = 2'h1;
	localparam logic [1:0] BOOT_CYC = 2'h3;
	localparam int CLK_NS = 25;
	localparam int CHIP_RST_NS = 102000;
	localparam logic [11:0] CHIP_RST_CYC = 12'((CHIP_RST_NS + CLK_NS - 1) / CLK_NS);
	typedef enum logic [2:0] {
		AN_BOOT = 3'b000,
		AN_IDLE = 3'b001,
		AN_CLEAR = 3'b010,
		AN_CMPL = 3'b011,
		AN_PAGE = 3'b100,
		AN_RES = 3'b101
	} ephy_an_e;
	typedef enum logic [2:0] {
		MD_IDLE = 3'b000,
		MD_ST = 3'b001,
		MD_HDR = 3'b010,
		MD_TA1 = 3'b011,
		MD_TA2 = 3'b100,
		MD_DATA = 3'b101
	} ephy_md_e;
endpackage

// ==== hdl/ephy_sync.sv ====
`timescale 1ns/100ps
`default_nettype none
module ephy_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rstN,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} ephy_sync_s;
	ephy_sync_s q;
	ephy_sync_s n;
	always_comb begin
		n.s1 = din;
		n.s2 = q.s1;
	end
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end
	assign dout = q.s2;
endmodule // ephy_sync
`default_nettype wire

// ==== hdl/ephy_hcd.sv ====
`timescale 1ns/100ps
`default_nettype none
module ephy_hcd (
	input wire logic [3:0] common,
	output logic pick100,
	output logic pickFull
);
	// Bits from msb: 100 full, 100 half, 10 full, 10 half
	always_comb begin
		pick100 = common[3] | common[2];
		pickFull = common[3] | (~common[2] & common[1]);
	end
endmodule // ephy_hcd
`default_nettype wire

// ==== hdl/ephy_autoneg_regs.sv ====
`timescale 1ns/100ps
`default_nettype none
module ephy_autoneg_regs (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic mdc,
	input wire logic mdioIn,
	output logic mdioOut,
	output logic mdioOe,
	input wire logic duplexPin,
	input wire logic duplexPolStrap,
	input wire logic speedStrap,
	input wire logic reloadStrobe,
	output logic irq,
	output logic opSpeed100,
	output logic opFullDuplex
);
	typedef struct packed {
		logic wbAck;
		logic [31:0] wbDat;
		logic [15:0] ctrl;
		logic [15:0] adv;
		logic [15:0] lp;
		logic anCmpl;
		logic pageRx;
		logic lpAble;
		ephy_pkg::ephy_an_e anSt;
		logic [1:0] boot;
		logic runReq;
		logic resSpd;
		logic resFdx;
		logic parDet;
		logic chipRst3;
		logic [11:0] chipTmr;
		logic [2:0] irqSt;
		logic [2:0] irqMask;
		logic irq;
		ephy_pkg::ephy_md_e mSt;
		logic [5:0] ones;
		logic [3:0] cnt;
		logic [11:0] hdr;
		logic [4:0] mReg;
		logic mRd;
		logic [15:0] sh;
		logic mdcPrev;
		logic mdioOut;
		logic mdioOe;
		logic opSpd;
		logic opFdx;
	} ephy_state_s;

	localparam ephy_state_s ST_RST = '{
		ctrl: ephy_pkg::CTRL_RST,
		adv: ephy_pkg::ADV_RST,
		lp: ephy_pkg::SEL_8023,
		anSt: ephy_pkg::AN_BOOT,
		runReq: 1'h1,
		mSt: ephy_pkg::MD_IDLE,
		default: '0
	};

	ephy_state_s q;
	ephy_state_s n;
	logic rstN;
	logic mdcS;
	logic mdioS;
	logic dupS;
	logic polS;
	logic spdS;
	logic [3:0] common;
	logic pick100;
	logic pickFull;

	////////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] regRead(input ephy_state_s s, input logic [4:0] idx);
		logic [15:0] r;
		r = 16'hFFFF;
		case (idx)
			ephy_pkg::R_CTRL: r = s.ctrl;
			ephy_pkg::R_STAT: r = ephy_pkg::STAT_BASE | {10'h000, s.anCmpl, 5'h00};
			ephy_pkg::R_ID1: r = ephy_pkg::ID1;
			ephy_pkg::R_ID2: r = ephy_pkg::ID2;
			ephy_pkg::R_ADV: r = s.adv;
			ephy_pkg::R_LP: r = s.lp;
			ephy_pkg::R_EXP: r = {14'h0000, s.pageRx, s.lpAble};
			default: r = 16'hFFFF;
		endcase
		return r;
	endfunction

	function automatic logic [31:0] busRead(input ephy_state_s s, input logic [7:0] aw);
		logic [31:0] r;
		r = 32'h0000_0000;
		if (aw < ephy_pkg::OFS_MII_END) begin
			r[15:0] = regRead(s, aw[6:2]);
		end else if (aw == ephy_pkg::OFS_CHIPRST) begin
			r[ephy_pkg::B_CHIP_VRST] = s.chipRst3;
		end else if (aw == ephy_pkg::OFS_IRQST) begin
			r[2:0] = s.irqSt;
		end else if (aw == ephy_pkg::OFS_IRQMASK) begin
			r[2:0] = s.irqMask;
		end else if (aw == ephy_pkg::OFS_RESULT) begin
			r[2:0] = {s.parDet, s.resFdx, s.resSpd};
		end
		return r;
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] d,
		input logic [1:0] sel);
		return {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
	endfunction

	////////////////////////////////////////////////////////////////////////////
	ephy_sync #(.W(1)) uRstSync (
		.clk(ref_clk),
		.rstN(resetn),
		.din(1'h1),
		.dout(rstN)
	);

	// Straps share the pin synchroniser; they are read only in a run, when it loads the partner and again (speed) at its result step
	ephy_sync #(.W(5)) uPinSync (
		.clk(ref_clk),
		.rstN(rstN),
		.din({mdc, mdioIn, duplexPin, duplexPolStrap, speedStrap}),
		.dout({mdcS, mdioS, dupS, polS, spdS})
	);

	assign common = q.adv[8:5] & q.lp[8:5];

	ephy_hcd uHcd (
		.common(common),
		.pick100(pick100),
		.pickFull(pickFull)
	);

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic rise;
		logic mdCommit;
		logic wbTake;
		logic wrEn;
		logic softRst;
		logic fdxP;
		logic [4:0] wrIdx;
		logic [15:0] wrData;
		logic [15:0] mdWord;
		logic [15:0] chipW;
		logic [2:0] irqSet;
		logic [2:0] irqClr;
		logic [7:0] aw;
		n = q;
		rise = mdcS & ~q.mdcPrev;
		mdWord = {q.sh[14:0], mdioS};
		mdCommit = rise & (q.mSt == ephy_pkg::MD_DATA) & (q.cnt == 4'hF) & ~q.mRd;
		aw = {wb_adr_i[7:2], 2'h0};
		// A bus cycle waits one clock if an MDIO write lands in the same cycle
		wbTake = wb_cyc_i & wb_stb_i & ~q.wbAck & ~mdCommit;
		wrEn = mdCommit | (wbTake & wb_we_i & (aw < ephy_pkg::OFS_MII_END));
		wrIdx = mdCommit ? q.mReg : aw[6:2];
		wrData = mdCommit ? mdWord : merge16(regRead(q, aw[6:2]), wb_dat_i[15:0], wb_sel_i[1:0]);
		chipW = merge16(16'h0000, wb_dat_i[15:0], wb_sel_i[1:0]);
		softRst = reloadStrobe;
		fdxP = (dupS == polS);
		irqSet = 3'h0;
		irqClr = 3'h0;
		n.mdcPrev = mdcS;

		if (q.chipRst3) begin
			if (q.chipTmr == ephy_pkg::CHIP_RST_CYC - 12'h001) begin
				n.chipRst3 = 1'h0;
				irqSet[ephy_pkg::I_VRST] = 1'h1;
			end else begin
				n.chipTmr = q.chipTmr + 12'h001;
			end
		end

		n.wbAck = wbTake;
		if (wbTake) begin
			n.wbDat = busRead(q, aw);
			if (wb_we_i && aw == ephy_pkg::OFS_CHIPRST) begin
				if (chipW[ephy_pkg::B_CHIP_VRST]) begin
					n.chipRst3 = 1'h1;
					n.chipTmr = 12'h000;
					softRst = 1'h1;
				end
				if (chipW[ephy_pkg::B_CHIP_DRST]) begin
					softRst = 1'h1;
				end
			end
			if (wb_we_i && aw == ephy_pkg::OFS_IRQST && wb_sel_i[0]) begin
				irqClr = wb_dat_i[2:0];
			end
			if (wb_we_i && aw == ephy_pkg::OFS_IRQMASK && wb_sel_i[0]) begin
				n.irqMask = wb_dat_i[2:0];
			end
		end

		if (wrEn && wrIdx == ephy_pkg::R_CTRL) begin
			if (wrData[ephy_pkg::B_CTRL_RST]) begin
				softRst = 1'h1;
			end else begin
				n.ctrl = wrData & ephy_pkg::CTRL_WMASK;
				if (wrData[ephy_pkg::B_RESTART] || (wrData[ephy_pkg::B_ANEN] && !q.ctrl[ephy_pkg::B_ANEN])) begin
					n.runReq = 1'h1;
				end
			end
		end
		if (wrEn && wrIdx == ephy_pkg::R_ADV) begin
			n.adv = (wrData & ephy_pkg::ADV_WMASK) | ephy_pkg::SEL_8023;
		end
		if (mdCommit) begin
			irqSet[ephy_pkg::I_MDWR] = 1'h1;
		end

		case (q.anSt)
			ephy_pkg::AN_BOOT: begin
				// Lets the pin synchroniser fill before the first run reads the straps
				n.boot = q.boot + 2'h1;
				if (q.boot == ephy_pkg::BOOT_CYC) begin
					n.anSt = ephy_pkg::AN_IDLE;
				end
			end
			ephy_pkg::AN_IDLE: begin
				if (q.runReq && !q.chipRst3) begin
					n.runReq = 1'h0;
					if (q.ctrl[ephy_pkg::B_ANEN]) begin
						n.anSt = ephy_pkg::AN_CLEAR;
					end
				end
			end
			ephy_pkg::AN_CLEAR: begin
				n.anCmpl = 1'h0;
				n.pageRx = 1'h0;
				n.lpAble = 1'h0;
				// Partner mirrors the fabric; pause follows local request
				n.lp = {4'h0, q.adv[11:10], 1'h0,
					spdS ? (fdxP ? 4'hC : 4'h4) : (fdxP ? 4'h3 : 4'h1), 5'h01};
				n.anSt = ephy_pkg::AN_CMPL;
			end
			ephy_pkg::AN_CMPL: begin
				n.anCmpl = 1'h1;
				n.anSt = ephy_pkg::AN_PAGE;
			end
			ephy_pkg::AN_PAGE: begin
				n.pageRx = 1'h1;
				n.anSt = ephy_pkg::AN_RES;
			end
			ephy_pkg::AN_RES: begin
				if (common != 4'h0) begin
					n.lpAble = 1'h1;
					n.resSpd = pick100;
					n.resFdx = pickFull;
					n.parDet = 1'h0;
				end else begin
					n.lpAble = 1'h0;
					n.resFdx = 1'h0;
					n.resSpd = spdS;
					n.parDet = 1'h1;
					n.lp[8:5] = spdS ? 4'h4 : 4'h1;
				end
				irqSet[ephy_pkg::I_AN] = 1'h1;
				n.anSt = ephy_pkg::AN_IDLE;
			end
			default: n.anSt = ephy_pkg::AN_IDLE;
		endcase

		if (softRst) begin
			n.ctrl = ephy_pkg::CTRL_RST;
			n.adv = ephy_pkg::ADV_RST;
			n.lp = ephy_pkg::SEL_8023;
			n.anCmpl = 1'h0;
			n.pageRx = 1'h0;
			n.lpAble = 1'h0;
			n.runReq = 1'h1;
			if (q.anSt != ephy_pkg::AN_BOOT) begin
				n.anSt = ephy_pkg::AN_IDLE;
			end
		end

		// Forced values only count with negotiation off
		n.opSpd = n.ctrl[ephy_pkg::B_ANEN] ? n.resSpd : n.ctrl[ephy_pkg::B_SPD];
		n.opFdx = n.ctrl[ephy_pkg::B_ANEN] ? n.resFdx : n.ctrl[ephy_pkg::B_DUP];

		// Set wins over a clear in the same cycle
		n.irqSt = (q.irqSt & ~irqClr) | irqSet;
		n.irq = |(n.irqSt & n.irqMask);

		if (rise) begin
			case (q.mSt)
				ephy_pkg::MD_IDLE: begin
					if (mdioS) begin
						if (q.ones != ephy_pkg::PRE_ONES) begin
							n.ones = q.ones + 6'h01;
						end
					end else begin
						if (q.ones == ephy_pkg::PRE_ONES) begin
							n.mSt = ephy_pkg::MD_ST;
						end
						n.ones = 6'h00;
					end
				end
				ephy_pkg::MD_ST: begin
					n.mSt = mdioS ? ephy_pkg::MD_HDR : ephy_pkg::MD_IDLE;
					n.cnt = 4'h0;
				end
				ephy_pkg::MD_HDR: begin
					n.hdr = {q.hdr[10:0], mdioS};
					n.cnt = q.cnt + 4'h1;
					if (q.cnt == 4'hB) begin
						n.mReg = n.hdr[4:0];
						n.mRd = (n.hdr[11:10] == ephy_pkg::MD_OP_RD);
						n.sh = regRead(q, n.hdr[4:0]);
						if (n.hdr[9:5] == ephy_pkg::PHY_ADDR && (n.hdr[11:10] == ephy_pkg::MD_OP_RD
							|| n.hdr[11:10] == ephy_pkg::MD_OP_WR)) begin
							n.mSt = ephy_pkg::MD_TA1;
						end else begin
							n.mSt = ephy_pkg::MD_IDLE;
						end
					end
				end
				ephy_pkg::MD_TA1: begin
					n.mdioOe = q.mRd;
					n.mdioOut = 1'h0;
					n.mSt = ephy_pkg::MD_TA2;
				end
				ephy_pkg::MD_TA2: begin
					n.mdioOut = q.sh[15];
					n.sh = {q.sh[14:0], 1'h0};
					n.cnt = 4'h0;
					n.mSt = ephy_pkg::MD_DATA;
				end
				ephy_pkg::MD_DATA: begin
					n.sh = mdWord;
					n.mdioOut = q.sh[15];
					n.cnt = q.cnt + 4'h1;
					if (q.cnt == 4'hF) begin
						n.mdioOe = 1'h0;
						n.mSt = ephy_pkg::MD_IDLE;
					end
				end
				default: n.mSt = ephy_pkg::MD_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			q <= ST_RST;
		end else begin
			q <= n;
		end
	end

	assign wb_ack_o = q.wbAck;
	assign wb_dat_o = q.wbDat;
	assign mdioOut = q.mdioOut;
	assign mdioOe = q.mdioOe;
	assign irq = q.irq;
	assign opSpeed100 = q.opSpd;
	assign opFullDuplex = q.opFdx;

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstN);

	a_run_sequence: assert property (q.anSt == ephy_pkg::AN_CLEAR |=>
		q.anSt == ephy_pkg::AN_CMPL ##1 q.anCmpl && !q.pageRx ##1 q.pageRx ##1
		q.anSt == ephy_pkg::AN_IDLE && q.anCmpl)
		else $error("negotiation steps out of order");
	a_restart_clear: assert property (q.anSt == ephy_pkg::AN_CLEAR |=>
		!q.anCmpl && !q.pageRx && !q.lpAble)
		else $error("flags not cleared on restart");
	a_run_needs_en: assert property ($rose(q.anSt == ephy_pkg::AN_CLEAR) |->
		$past(q.ctrl[ephy_pkg::B_ANEN]))
		else $error("negotiation ran while disabled");
	a_forced_mode: assert property (!q.ctrl[ephy_pkg::B_ANEN] |->
		q.opSpd == q.ctrl[ephy_pkg::B_SPD] && q.opFdx == q.ctrl[ephy_pkg::B_DUP])
		else $error("forced speed or duplex not applied");
	a_parallel_half: assert property (q.anSt == ephy_pkg::AN_RES && common == 4'h0 |=>
		!q.lpAble && !q.resFdx && q.resSpd == $past(spdS) && $onehot(q.lp[8:5]))
		else $error("parallel detect result wrong");
	a_common_able: assert property (q.anSt == ephy_pkg::AN_RES && common != 4'h0 |=>
		q.lpAble && $stable(q.lp))
		else $error("partner able not set");
	a_top_priority: assert property (q.anSt == ephy_pkg::AN_RES && common[3] |=>
		q.resSpd && q.resFdx)
		else $error("100 full not chosen first");
	a_result_hold: assert property (q.anSt == ephy_pkg::AN_IDLE &&
		$past(q.anSt) == ephy_pkg::AN_IDLE |-> $stable(q.resSpd) && $stable(q.resFdx))
		else $error("result changed outside a run");
	a_no_t4: assert property (q.lp[15:13] == 3'h0 && q.lp[9] == 1'h0 &&
		q.adv[15:13] == 3'h0 && q.adv[9] == 1'h0)
		else $error("forbidden capability advertised");
	a_adv_default: assert property ($rose(q.anSt == ephy_pkg::AN_IDLE) &&
		$past(q.anSt) == ephy_pkg::AN_BOOT |-> q.adv[8:5] == 4'hF)
		else $error("advertisement default wrong");
	a_chip_rst_time: assert property ($fell(q.chipRst3) |->
		$past(q.chipTmr) == ephy_pkg::CHIP_RST_CYC - 12'h001)
		else $error("emulated reset bit cleared early");
	a_ack_pulse: assert property (q.wbAck |=> !q.wbAck)
		else $error("ack held longer than one cycle");

	c_parallel: cover property (q.anSt == ephy_pkg::AN_RES && common == 4'h0);
	c_common: cover property (q.anSt == ephy_pkg::AN_RES && common != 4'h0);
	c_mdio_read: cover property (q.mSt == ephy_pkg::MD_DATA && q.mRd ##1 q.mSt == ephy_pkg::MD_IDLE);
	c_chip_rst: cover property ($fell(q.chipRst3));
endmodule // ephy_autoneg_regs
`default_nettype wire

// ==== sim/ephy_mdio_master.sv ====
`timescale 1ns/100ps
`default_nettype none
module ephy_mdio_master (
	output logic mdc,
	output logic txData,
	output logic txEn,
	input wire logic wireLevel
);
	// Link clock stands low between frames and has a 200 ns period inside them
	initial begin
		mdc = 1'h0;
		txData = 1'h0;
		txEn = 1'h0;
	end
	task automatic sendBit(input logic b);
		txData = b;
		#100 mdc = 1'h1;
		#100 mdc = 1'h0;
	endtask
	// Read bits are taken at the rising edge, before the device moves to its next bit
	task automatic frame(input logic [1:0] op, input logic [4:0] regAdr, input logic [15:0] wd,
			output logic [17:0] rd);
		logic [63:0] bits;
		int i;
		bits = {32'hFFFF_FFFF, 2'h1, op, ephy_pkg::PHY_ADDR, regAdr, 2'h2, wd};
		rd = 18'h0_0000;
		txEn = 1'h1;
		for (i = 63; i >= 0; i--) begin
			if (i == 17 && op == ephy_pkg::MD_OP_RD) begin
				txEn = 1'h0;
			end
			if (txEn) begin
				sendBit(bits[i]);
			end else begin
				#100 mdc = 1'h1;
				rd = {rd[16:0], wireLevel};
				#100 mdc = 1'h0;
			end
		end
		txEn = 1'h0;
	endtask
endmodule // ephy_mdio_master
`default_nettype wire

// ==== sim/test_ephy_autoneg_regs.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin nMismatch++; $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_ephy_autoneg_regs;
	logic refClk, cyc = 1'h0, stb = 1'h0, we = 1'h0, resetN = 1'h0, reload = 1'h0;
	logic dupPin = 1'h1, dupPol = 1'h1, spdStrap = 1'h1;
	logic [7:0] adr = 8'h00;
	logic [31:0] datW = 32'h0000_0000;
	wire logic [31:0] datR;
	wire logic ack, mdOut, mdOe, irq, spd100, fullDup, mdc, mTx, mEn, mdWire;
	int nMismatch = 0, nCompared = 0, cycles = 0;
	logic [15:0] aTab [4] = '{16'h01E1, 16'h00A1, 16'h0061, 16'h0021};
	logic sTab [4] = '{1'h1, 1'h1, 1'h0, 1'h0};
	logic [2:0] rTab [5] = '{3'h3, 3'h3, 3'h1, 3'h2, 3'h0};
	logic [15:0] lTab [5] = '{16'h0180, 16'h0180, 16'h0180, 16'h0060, 16'h0060};
	// MDIO has a pull-up: released by both parties it reads high
	assign mdWire = mdOe ? mdOut : (mEn ? mTx : 1'h1);
	ephy_autoneg_regs uut (.ref_clk(refClk), .resetn(resetN), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(datW), .wb_dat_o(datR),
		.wb_ack_o(ack), .mdc(mdc), .mdioIn(mdWire), .mdioOut(mdOut), .mdioOe(mdOe),
		.duplexPin(dupPin), .duplexPolStrap(dupPol), .speedStrap(spdStrap),
		.reloadStrobe(reload), .irq(irq), .opSpeed100(spd100), .opFullDuplex(fullDup));
	ephy_mdio_master mdioM (.mdc(mdc), .txData(mTx), .txEn(mEn), .wireLevel(mdWire));
	initial begin
		refClk = 1'h0;
		forever #12.5 refClk = ~refClk;
	end
	always @(posedge refClk) begin
		cycles++;
		if (cycles == 30000) begin
			nMismatch++;
			endSim();
		end
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		datW <= d;
		do begin @(posedge refClk); n++; end while (ack !== 1'h1 && n < 20);
		q = datR;
		cyc <= 1'h0;
		stb <= 1'h0;
		`CHK(n < 20, 1'h1)
		@(posedge refClk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [31:0] q;
		wb(1'h1, a, {16'h0000, d}, q);
	endtask
	task automatic rdChk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] q;
		wb(1'h0, a, 32'h0000_0000, q);
		`CHK(q & m, e)
	endtask
	task automatic waitIrq(input int lim, output int n);
		n = 0;
		while (irq !== 1'h1 && n < lim) begin @(posedge refClk); n++; end
		`CHK(irq, 1'h1)
	endtask
	// Clears the run-finished flag first so a stale one cannot pass for this run
	task automatic kick(input logic [7:0] a, input logic [15:0] d);
		int n;
		wr(8'h44, 16'h0007);
		wr(a, d);
		waitIrq(50, n);
	endtask
	task automatic chkRes(input logic [2:0] r, input logic [15:0] lp);
		rdChk(8'h4C, 32'h0000_0007, {29'h0, r});
		rdChk(8'h14, 32'h0000_01E0, {16'h0000, lp});
		rdChk(8'h18, 32'h0000_FFFF, {30'h0, 1'h1, ~r[2]});
		`CHK({fullDup, spd100}, r[1:0])
	endtask
	task automatic md(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] d, output logic [17:0] q);
		mdioM.frame(op, ra, d, q);
		@(posedge refClk);
	endtask
	task endSim;
		$display("compared %0d, mismatched %0d", nCompared, nMismatch);
		if (nMismatch == 0 && nCompared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [17:0] q;
		int n;
		int i;
		repeat (5) @(posedge refClk);
		resetN <= 1'h1;
		repeat (20) @(posedge refClk);
		rdChk(8'h00, 32'h0000_FFFF, 32'h0000_3100);
		rdChk(8'h10, 32'h0000_FFFF, 32'h0000_01E1);
		rdChk(8'h04, 32'h0000_FFFF, {16'h0000, ephy_pkg::STAT_BASE | 16'h0020});
		chkRes(3'h3, 16'h0180);
		rdChk(8'h30, 32'hFFFF_FFFF, 32'h0000_0000);
		wr(8'h48, 16'h0001);
		$display("test reset done");
		for (i = 0; i < 4; i++) begin
			spdStrap <= sTab[i];
			wr(8'h10, aTab[i]);
			rdChk(8'h10, 32'h0000_FFFF, {16'h0000, aTab[i]});
			chkRes(rTab[i], lTab[i]);
			kick(8'h00, 16'h3300);
			chkRes(rTab[i + 1], lTab[i + 1]);
		end
		wr(8'h10, 16'h0181);
		kick(8'h00, 16'h3300);
		chkRes(3'h4, 16'h0020);
		wr(8'h10, 16'hFFFF);
		rdChk(8'h10, 32'h0000_FFFF, 32'h0000_0DE1);
		$display("test priority done");
		wr(8'h00, 16'h3100);
		repeat (4) @(posedge refClk);
		`CHK({fullDup, spd100}, 2'h0)
		wr(8'h00, 16'h2100);
		repeat (4) @(posedge refClk);
		`CHK({fullDup, spd100}, 2'h3)
		wr(8'h00, 16'h0000);
		repeat (4) @(posedge refClk);
		`CHK({fullDup, spd100}, 2'h0)
		kick(8'h00, 16'h8000);
		rdChk(8'h00, 32'h0000_FFFF, 32'h0000_3100);
		rdChk(8'h10, 32'h0000_FFFF, 32'h0000_01E1);
		chkRes(3'h2, 16'h0060);
		kick(8'h40, 16'h0400);
		wr(8'h44, 16'h0007);
		reload <= 1'h1;
		@(posedge refClk);
		reload <= 1'h0;
		waitIrq(50, n);
		$display("test resets done");
		wr(8'h48, 16'h0004);
		wr(8'h44, 16'h0007);
		wr(8'h40, 16'h0008);
		rdChk(8'h40, 32'h0000_0008, 32'h0000_0008);
		waitIrq(5000, n);
		`CHK(n > 3900 && n < 4200, 1'h1)
		rdChk(8'h40, 32'h0000_0008, 32'h0000_0000);
		repeat (20) @(posedge refClk);
		wr(8'h48, 16'h0001);
		$display("test chip reset done");
		md(ephy_pkg::MD_OP_RD, ephy_pkg::R_ID1, 16'h0000, q);
		`CHK(q, {2'h2, ephy_pkg::ID1})
		md(ephy_pkg::MD_OP_RD, ephy_pkg::R_STAT, 16'h0000, q);
		`CHK(q, {2'h2, ephy_pkg::STAT_BASE | 16'h0020})
		md(ephy_pkg::MD_OP_RD, 5'h07, 16'h0000, q);
		`CHK(q, {2'h2, 16'hFFFF})
		wr(8'h44, 16'h0007);
		md(ephy_pkg::MD_OP_WR, ephy_pkg::R_ADV, 16'h0061, q);
		rdChk(8'h10, 32'h0000_FFFF, 32'h0000_0061);
		`CHK(irq, 1'h0)
		rdChk(8'h44, 32'h0000_0002, 32'h0000_0002);
		wr(8'h48, 16'h0003);
		repeat (2) @(posedge refClk);
		`CHK(irq, 1'h1)
		wr(8'h44, 16'h0002);
		repeat (2) @(posedge refClk);
		`CHK(irq, 1'h0)
		$display("test mdio done");
		endSim();
	end
endmodule // test_ephy_autoneg_regs
`default_nettype wire
